// ===== tcr_consts.vh
// Offsets, reset values and sizes of the totalizer control register bank
`ifndef TCR_CONSTS_VH
`define TCR_CONSTS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define TCR_IDX_READING     16'h0004
`define TCR_IDX_CLR_MASK    16'h1F10
`define TCR_IDX_SEL_EN      16'h1F11
`define TCR_IDX_BOOT_MASK   16'h1F20
`define TCR_IDX_CLRABLE     16'h1F30
`define TCR_IDX_SEL_CLR     16'h1F50
`define TCR_IDX_RECALL      16'hFFFC

// ----------------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------------
`define TCR_RST_CLRABLE     16'hFFFE
`define TCR_RST_EN_MASK     16'h0000
`define TCR_RST_BOOT_MASK   16'h0000
`define TCR_NUM_TOT         16
`define TCR_FAC_SLOTS       4
`define TCR_CFG_W           48
`define TCR_RSP_OK          2'h0
`define TCR_RSP_DECERR      2'h3

`endif

// ===== tcr_factory_store.v
// Factory configuration images and their recall by index
`default_nettype none
`include "tcr_consts.vh"

module tcr_factory_store (
    input  wire                  core_clk_i,
    input  wire                  rstn_i,
    input  wire                  prog_wr_i,
    input  wire [1:0]            prog_idx_i,
    input  wire [`TCR_CFG_W-1:0] prog_cfg_i,
    input  wire                  recall_i,
    input  wire [15:0]           recall_idx_i,
    output reg                   load_o,
    output reg  [`TCR_CFG_W-1:0] load_cfg_o
);

    reg [`TCR_CFG_W-1:0]    image_reg [0:`TCR_FAC_SLOTS-1];
    reg [`TCR_FAC_SLOTS-1:0] valid_reg;
    integer                 i;

    wire idx_ok = (recall_idx_i < `TCR_FAC_SLOTS);

    // ------------------------------------------------------------------------
    // Image programming and recall
    // ------------------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            valid_reg  <= {`TCR_FAC_SLOTS{1'b0}};
            load_o     <= 1'b0;
            load_cfg_o <= {`TCR_CFG_W{1'b0}};
            for (i = 0; i < `TCR_FAC_SLOTS; i = i + 1) begin
                image_reg[i] <= {`TCR_CFG_W{1'b0}};
            end
        end else begin
            if (prog_wr_i) begin
                image_reg[prog_idx_i] <= prog_cfg_i;
                valid_reg[prog_idx_i] <= 1'b1;
            end
            // Bad index: nothing happens; empty slot: load_cfg_o is loaded but load_o stays low
            load_o <= recall_i && idx_ok && valid_reg[recall_idx_i[1:0]];
            if (recall_i && idx_ok) begin
                load_cfg_o <= image_reg[recall_idx_i[1:0]];
            end
        end
    end

endmodule
`default_nettype wire

// ===== tcr_regs.v
// Totalizer control register bank: Avalon-MM slave, startup clear, recall
`default_nettype none
`include "tcr_consts.vh"

module tcr_regs (
    input  wire                  core_clk_i,
    input  wire                  rstn_i,
    // Avalon-MM slave, byte addressed
    input  wire [17:0]           avs_address_i,
    input  wire                  avs_read_i,
    input  wire                  avs_write_i,
    input  wire [31:0]           avs_writedata_i,
    input  wire [3:0]            avs_byteenable_i,
    output reg  [31:0]           avs_readdata_o,
    output reg  [1:0]            avs_response_o,
    output reg                   avs_waitrequest_o,
    // Active profile, chosen elsewhere
    input  wire [3:0]            profile_sel_i,
    // Updated totals from the accumulation engine
    input  wire                  acc_valid_i,
    input  wire [3:0]            acc_idx_i,
    input  wire [31:0]           acc_value_i,
    // Persistent memory side
    input  wire [15:0]           nv_boot_mask_i,
    output reg                   nv_save_o,
    output reg  [15:0]           nv_save_data_o,
    output reg  [15:0]           persist_mask_o,
    // Factory image programming
    input  wire                  fac_prog_wr_i,
    input  wire [1:0]            fac_prog_idx_i,
    input  wire [`TCR_CFG_W-1:0] fac_prog_cfg_i,
    // Status
    output reg  [15:0]           tot_enable_mask_o,
    output reg                   boot_done_o
);

    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [1:0] ST_CAPTURE = 2'h0;
    localparam [1:0] ST_CLEAR   = 2'h1;
    localparam [1:0] ST_RUN     = 2'h2;

    reg  [1:0]            state_reg;
    reg  [1:0]            state_next;
    reg  [15:0]           clrable_reg;
    reg  [15:0]           en_mask_reg;
    reg  [15:0]           boot_mask_reg;
    reg  [15:0]           clear_vec;
    wire [31:0]           sel_value;
    wire                  fac_load;
    wire [`TCR_CFG_W-1:0] fac_cfg;

    // ------------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------------
    function hit;
        input [17:0] addr;
        input [15:0] idx;
        begin
            hit = (addr[17:2] == idx) && (addr[1:0] == 2'h0);
        end
    endfunction

    function [31:0] lanes;
        input [31:0] data;
        input [3:0]  be;
        begin
            lanes = data & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    // Request is taken once, in the cycle where waitrequest is still high
    wire        take     = (avs_read_i || avs_write_i) && avs_waitrequest_o && (state_reg == ST_RUN);
    wire        wr_take  = take && avs_write_i;
    wire [31:0] wdata    = lanes(avs_writedata_i, avs_byteenable_i);
    wire [15:0] sel_hot  = 16'h0001 << profile_sel_i;

    wire h_reading = hit(avs_address_i, `TCR_IDX_READING);
    wire h_clrmask = hit(avs_address_i, `TCR_IDX_CLR_MASK);
    wire h_sel_en  = hit(avs_address_i, `TCR_IDX_SEL_EN);
    wire h_boot    = hit(avs_address_i, `TCR_IDX_BOOT_MASK);
    wire h_clrable = hit(avs_address_i, `TCR_IDX_CLRABLE);
    wire h_sel_clr = hit(avs_address_i, `TCR_IDX_SEL_CLR);
    wire h_recall  = hit(avs_address_i, `TCR_IDX_RECALL);
    wire mapped    = h_reading | h_clrmask | h_sel_en | h_boot | h_clrable | h_sel_clr | h_recall;

    // ------------------------------------------------------------------------
    // Clear requests
    // ------------------------------------------------------------------------
    always @* begin
        clear_vec = 16'h0000;
        if (state_reg == ST_CLEAR) begin
            clear_vec = boot_mask_reg;
        end else if (wr_take && h_clrmask) begin
            // Only the low sixteen bits reach the bank
            clear_vec = wdata[15:0] & clrable_reg;
        end else if (wr_take && h_sel_clr) begin
            clear_vec = sel_hot & clrable_reg;
        end else if (wr_take && h_reading && (wdata == 32'h00000000)) begin
            // Non-zero value writes fall through untouched
            clear_vec = sel_hot & clrable_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Startup sequence
    // ------------------------------------------------------------------------
    always @* begin
        case (state_reg)
            ST_CAPTURE: state_next = ST_CLEAR;
            ST_CLEAR:   state_next = ST_RUN;
            ST_RUN:     state_next = ST_RUN;
            default:    state_next = ST_CAPTURE;
        endcase
    end

    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            state_reg   <= ST_CAPTURE;
            boot_done_o <= 1'b0;
        end else begin
            state_reg   <= state_next;
            boot_done_o <= (state_next == ST_RUN);
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            clrable_reg   <= `TCR_RST_CLRABLE;
            en_mask_reg   <= `TCR_RST_EN_MASK;
            boot_mask_reg <= `TCR_RST_BOOT_MASK;
        end else if (state_reg == ST_CAPTURE) begin
            // Mask held in persistent memory is taken after reset release
            boot_mask_reg <= nv_boot_mask_i;
        end else if (wr_take) begin
            if (h_boot) begin
                boot_mask_reg <= wdata[15:0];
            end
            if (h_clrable) begin
                clrable_reg <= wdata[15:0];
            end
            if (h_sel_en) begin
                if (wdata != 32'h00000000) begin
                    en_mask_reg <= en_mask_reg | sel_hot;
                end else begin
                    en_mask_reg <= en_mask_reg & ~sel_hot;
                end
            end
        end else if (fac_load) begin
            // Only configuration is replaced; the bank is not touched
            en_mask_reg   <= fac_cfg[47:32];
            clrable_reg   <= fac_cfg[31:16];
            boot_mask_reg <= fac_cfg[15:0];
        end
    end

    // ------------------------------------------------------------------------
    // Persistent memory outputs
    // ------------------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            nv_save_o      <= 1'b0;
            nv_save_data_o <= 16'h0000;
            persist_mask_o <= 16'hFFFF;
        end else begin
            nv_save_o <= wr_take && h_boot;
            if (wr_take && h_boot) begin
                nv_save_data_o <= wdata[15:0];
            end
            // Totals with startup clear are not written back
            persist_mask_o <= ~boot_mask_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Bus answer: one cycle after the request is seen
    // ------------------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h00000000;
            avs_response_o    <= `TCR_RSP_OK;
            tot_enable_mask_o <= `TCR_RST_EN_MASK;
        end else begin
            tot_enable_mask_o <= en_mask_reg;
            if (take) begin
                avs_waitrequest_o <= 1'b0;
                avs_response_o    <= mapped ? `TCR_RSP_OK : `TCR_RSP_DECERR;
                avs_readdata_o    <= 32'h00000000;
                if (avs_read_i) begin
                    if (h_reading) begin
                        avs_readdata_o <= sel_value;
                    end else if (h_sel_en) begin
                        avs_readdata_o <= {31'h00000000, |(en_mask_reg & sel_hot)};
                    end else if (h_boot) begin
                        avs_readdata_o <= {16'h0000, boot_mask_reg};
                    end else if (h_clrable) begin
                        avs_readdata_o <= {16'h0000, clrable_reg};
                    end
                end
            end else begin
                avs_waitrequest_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------------
    tcr_total_bank u_bank (
        .core_clk_i  (core_clk_i),
        .rstn_i      (rstn_i),
        .clear_vec_i (clear_vec),
        .en_mask_i   (en_mask_reg),
        .acc_valid_i (acc_valid_i),
        .acc_idx_i   (acc_idx_i),
        .acc_value_i (acc_value_i),
        .rd_idx_i    (profile_sel_i),
        .rd_value_o  (sel_value)
    );

    tcr_factory_store u_fac (
        .core_clk_i   (core_clk_i),
        .rstn_i       (rstn_i),
        .prog_wr_i    (fac_prog_wr_i),
        .prog_idx_i   (fac_prog_idx_i),
        .prog_cfg_i   (fac_prog_cfg_i),
        .recall_i     (wr_take && h_recall),
        .recall_idx_i (wdata[15:0]),
        .load_o       (fac_load),
        .load_cfg_o   (fac_cfg)
    );

endmodule
`default_nettype wire

// ===== tcr_regs_sva.sv
// Port-level assertions for the totalizer control register bank
`default_nettype none
`include "tcr_consts.vh"
module tcr_regs_sva (
    input wire logic        core_clk_i,
    input wire logic        rstn_i,
    input wire logic [17:0] avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic [1:0]  avs_response_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [3:0]  profile_sel_i,
    input wire logic        nv_save_o,
    input wire logic [15:0] nv_save_data_o,
    input wire logic [15:0] persist_mask_o,
    input wire logic [15:0] tot_enable_mask_o,
    input wire logic        boot_done_o
);
    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    wire [15:0] idx = avs_address_i[17:2];
    wire [15:0] wd = avs_writedata_i[15:0] & {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    // Enable follows the whole masked word, upper lanes included
    wire [31:0] wd_full = avs_writedata_i & {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    wire        take = (avs_read_i | avs_write_i) & avs_waitrequest_o & boot_done_o;
    wire        mapped = (avs_address_i[1:0] == 2'h0) && (idx == `TCR_IDX_READING || idx == `TCR_IDX_CLR_MASK ||
                idx == `TCR_IDX_SEL_EN || idx == `TCR_IDX_BOOT_MASK || idx == `TCR_IDX_CLRABLE ||
                idx == `TCR_IDX_SEL_CLR || idx == `TCR_IDX_RECALL);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_wr(i);
        take && avs_write_i && idx == i;
    endsequence
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_wait_single: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o) else $error("wait low too long");
    a_take_answer: assert property (take |=> !avs_waitrequest_o) else $error("no answer after take");
    a_boot_hold: assert property (!boot_done_o |-> avs_waitrequest_o) else $error("answer during startup");
    a_answer_cause: assert property ($fell(avs_waitrequest_o) |-> $past(take)) else $error("answer without take");
    a_decode_err: assert property (take && !mapped |=> avs_response_o == `TCR_RSP_DECERR && avs_readdata_o == 32'h0)
        else $error("unmapped access not refused");
    a_save_pulse: assert property (s_wr(`TCR_IDX_BOOT_MASK) |=> nv_save_o && nv_save_data_o == $past(wd) ##1 !nv_save_o)
        else $error("startup mask not saved");
    a_persist_mask: assert property (s_wr(`TCR_IDX_BOOT_MASK) |=> ##1 persist_mask_o == ~$past(wd, 2))
        else $error("persist mask wrong");
    a_enable_copy: assert property (s_wr(`TCR_IDX_SEL_EN) |=> ##1
        tot_enable_mask_o[$past(profile_sel_i, 2)] == ($past(wd_full, 2) != 32'h0)) else $error("enable not applied");
endmodule
bind tcr_regs tcr_regs_sva u_sva (.core_clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_response_o, .avs_waitrequest_o, .profile_sel_i, .nv_save_o,
    .nv_save_data_o, .persist_mask_o, .tot_enable_mask_o, .boot_done_o);
`default_nettype wire

// ===== tcr_regs_test.sv
// Self-checking bench for the totalizer control register bank
`default_nettype none
`include "tcr_consts.vh"
module tcr_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o, acc_valid_i;
    logic        fac_prog_wr_i, nv_save_o, boot_done_o;
    logic [17:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, acc_value_i;
    logic [3:0]  avs_byteenable_i, profile_sel_i, acc_idx_i;
    logic [1:0]  avs_response_o, fac_prog_idx_i;
    logic [15:0] nv_boot_mask_i, nv_save_data_o, persist_mask_o, tot_enable_mask_o;
    logic [47:0] fac_prog_cfg_i;
    int          err_count, compares, cycles;
    tcr_regs u_dut (.core_clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_response_o, .avs_waitrequest_o, .profile_sel_i, .acc_valid_i,
        .acc_idx_i, .acc_value_i, .nv_boot_mask_i, .nv_save_o, .nv_save_data_o, .persist_mask_o, .fac_prog_wr_i,
        .fac_prog_idx_i, .fac_prog_cfg_i, .tot_enable_mask_o, .boot_done_o);
    // ------------------------------------------------------------------
    // Clock, timeout and verdict
    // ------------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    task automatic end_of_test;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_of_test;
        end
    end
    // ------------------------------------------------------------------
    // Bus and stimulus tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is seen low; trailing edge keeps drivers single per step
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] d, output logic [31:0] q,
                        output logic [1:0] r);
        avs_address_i   <= {idx, 2'b00};
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        @(posedge core_clk_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge core_clk_i);
        q = avs_readdata_o;
        r = avs_response_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] rsp);
        logic [31:0] q;
        logic [1:0]  r;
        xfer(1'b0, idx, 32'h0, q, r);
        chk(q, exp);
        chk({30'h0, r}, {30'h0, rsp});
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] q;
        logic [1:0]  r;
        xfer(1'b1, idx, d, q, r);
        chk({30'h0, r}, 32'h0);
    endtask
    task automatic acc(input logic [3:0] i, input logic [31:0] v);
        acc_idx_i   <= i;
        acc_value_i <= v;
        acc_valid_i <= 1'b1;
        @(posedge core_clk_i);
        acc_valid_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rstn_i, avs_read_i, avs_write_i, acc_valid_i, fac_prog_wr_i} <= 5'h0;
        {avs_address_i, avs_writedata_i, profile_sel_i, acc_idx_i, acc_value_i} <= '0;
        {fac_prog_idx_i, fac_prog_cfg_i} <= '0;
        avs_byteenable_i <= 4'hF;
        nv_boot_mask_i   <= 16'h0006;
        repeat (2) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        rd(`TCR_IDX_CLRABLE, 32'hFFFE, 2'h0);
        rd(`TCR_IDX_BOOT_MASK, 32'h0006, 2'h0);
        chk({16'h0, persist_mask_o}, 32'h0000FFF9);
        for (int p = 0; p < 16; p++) begin
            profile_sel_i <= p[3:0];
            wr(`TCR_IDX_SEL_EN, 32'h0100);
            rd(`TCR_IDX_SEL_EN, 32'h1, 2'h0);
            acc(p[3:0], 32'h100 + p);
            rd(`TCR_IDX_READING, 32'h100 + p, 2'h0);
        end
        wr(`TCR_IDX_CLR_MASK, 32'hFFFFC005);
        for (int p = 0; p < 16; p++) begin
            profile_sel_i <= p[3:0];
            rd(`TCR_IDX_READING, (p == 2 || p >= 14) ? 32'h0 : 32'h100 + p, 2'h0);
        end
        profile_sel_i <= 4'h3;
        wr(`TCR_IDX_SEL_EN, 32'h0);
        rd(`TCR_IDX_SEL_EN, 32'h0, 2'h0);
        acc(4'h3, 32'h777);
        rd(`TCR_IDX_READING, 32'h103, 2'h0);
        wr(`TCR_IDX_SEL_CLR, 32'h1234);
        rd(`TCR_IDX_READING, 32'h0, 2'h0);
        profile_sel_i <= 4'h0;
        wr(`TCR_IDX_SEL_CLR, 32'h1);
        wr(`TCR_IDX_READING, 32'h0);
        rd(`TCR_IDX_READING, 32'h100, 2'h0);
        profile_sel_i <= 4'h4;
        wr(`TCR_IDX_READING, 32'h5);
        rd(`TCR_IDX_READING, 32'h104, 2'h0);
        wr(`TCR_IDX_READING, 32'h0);
        rd(`TCR_IDX_READING, 32'h0, 2'h0);
        wr(`TCR_IDX_BOOT_MASK, 32'hFFFFC004);
        rd(`TCR_IDX_BOOT_MASK, 32'hC004, 2'h0);
        chk({16'h0, persist_mask_o}, 32'h00003FFB);
        rd(`TCR_IDX_CLR_MASK, 32'h0, 2'h0);
        rd(16'h0123, 32'h0, `TCR_RSP_DECERR);
        fac_prog_idx_i <= 2'h1;
        fac_prog_cfg_i <= {16'h0020, 16'h0001, 16'h0000};
        fac_prog_wr_i  <= 1'b1;
        @(posedge core_clk_i);
        fac_prog_wr_i <= 1'b0;
        wr(`TCR_IDX_RECALL, 32'h7);
        wr(`TCR_IDX_RECALL, 32'h2);
        rd(`TCR_IDX_CLRABLE, 32'hFFFE, 2'h0);
        wr(`TCR_IDX_RECALL, 32'h1);
        rd(`TCR_IDX_CLRABLE, 32'h0001, 2'h0);
        rd(`TCR_IDX_BOOT_MASK, 32'h0, 2'h0);
        profile_sel_i <= 4'h6;
        rd(`TCR_IDX_SEL_EN, 32'h0, 2'h0);
        rd(`TCR_IDX_READING, 32'h106, 2'h0);
        wr(`TCR_IDX_CLR_MASK, 32'h0040);
        rd(`TCR_IDX_READING, 32'h106, 2'h0);
        end_of_test;
    end
endmodule
`default_nettype wire

// ===== tcr_total_bank.v
// Sixteen accumulated totals, one per profile, with per-entry clear
`default_nettype none

module tcr_total_bank (
    input  wire        core_clk_i,
    input  wire        rstn_i,
    input  wire [15:0] clear_vec_i,
    input  wire [15:0] en_mask_i,
    input  wire        acc_valid_i,
    input  wire [3:0]  acc_idx_i,
    input  wire [31:0] acc_value_i,
    input  wire [3:0]  rd_idx_i,
    output wire [31:0] rd_value_o
);

    reg [31:0] total_reg [0:15];
    integer    i;

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    always @(posedge core_clk_i) begin
        for (i = 0; i < 16; i = i + 1) begin
            if (!rstn_i) begin
                total_reg[i] <= 32'h00000000;
            end else if (clear_vec_i[i]) begin
                // Clear beats a same-cycle update; disabled entries clear too
                total_reg[i] <= 32'h00000000;
            end else if (acc_valid_i && (acc_idx_i == i[3:0]) && en_mask_i[i]) begin
                total_reg[i] <= acc_value_i;
            end
        end
    end

    assign rd_value_o = total_reg[rd_idx_i];

endmodule
`default_nettype wire
